// *** bench/ext_mem_model.sv ***
// Purpose : behavioural external data memory on the far side of the access block
// Assumes : strobes active low, read data returned while the read strobe is low
// Notes   : released bus shows a pattern that flips every clock, never the last value
`timescale 1ns/1ps
module ext_mem_model
(
  input  wire logic        ref_clk_in,  // block clock
  input  wire logic [15:0] addr_in,     // external address
  input  wire logic        rd_n_in,     // read strobe, low active
  input  wire logic        wr_n_in,     // write strobe, low active
  input  wire logic [7:0]  wdata_in,    // data from the block
  input  wire logic        data_oe_in,  // block drives the data bus
  output logic      [7:0]  rdata_out,   // data bus towards the block
  output logic      [15:0] wr_addr_out, // last written address
  output logic      [7:0]  wr_data_out  // last written byte
);
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] junk_r;
  // junk flips each clock so a late capture never sees a stale match; settles from unknown on the first edge
  always_ff @(posedge ref_clk_in)
    junk_r <= (junk_r === 8'h5A) ? 8'hA5 : 8'h5A;
  // answers at once, well inside even the shortest strobe
  assign rdata_out = rd_n_in ? junk_r : (addr_in[7:0] ^ addr_in[15:8] ^ 8'hA5);
  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // byte taken at every clock of the strobe; the last one is what stays
  always_ff @(posedge ref_clk_in)
    if (!wr_n_in && data_oe_in)
    begin
      wr_addr_out <= addr_in;
      wr_data_out <= wdata_in;
    end
endmodule : ext_mem_model

// *** bench/test_ext_data_access_stretch.sv ***
// Purpose : self-checking bench for the external data access timing block
// Assumes : 250 MHz clock, register read data one cycle after the strobe
// Notes   : every scenario is its own task and judges its own results
`timescale 1ns/1ps
module test_ext_data_access_stretch;
  import ext_access_pkg::*;
  logic ref_clk_in, reset_n_in, reg_wr_in, reg_rd_in, instr_req_in, ext_move_in, ext_use_ptr_in;
  logic ext_write_in, ptr_inc_in, busy_out, fetch_out, done_out, rd_n_out, wr_n_out, ext_data_oe_out;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, ind_ptr_in, port2_in, ext_wdata_in;
  logic [7:0]  ext_rdata_in, ext_wdata_out, rdata_out, m_wdata;
  logic [2:0]  op_bytes_in, op_cycles_in;
  logic [3:0]  phase_out;
  logic [15:0] ext_addr_out, m_waddr;
  int          n_fail, checks_done;

  ext_data_access_stretch DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .instr_req_in(instr_req_in), .op_bytes_in(op_bytes_in), .op_cycles_in(op_cycles_in),
    .ext_move_in(ext_move_in), .ext_use_ptr_in(ext_use_ptr_in), .ext_write_in(ext_write_in),
    .ind_ptr_in(ind_ptr_in), .port2_in(port2_in), .ext_wdata_in(ext_wdata_in), .ptr_inc_in(ptr_inc_in),
    .ext_rdata_in(ext_rdata_in), .phase_out(phase_out), .busy_out(busy_out), .fetch_out(fetch_out),
    .done_out(done_out), .ext_addr_out(ext_addr_out), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
    .ext_wdata_out(ext_wdata_out), .ext_data_oe_out(ext_data_oe_out), .rdata_out(rdata_out));
  ext_mem_model mem (.ref_clk_in(ref_clk_in), .addr_in(ext_addr_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .wdata_in(ext_wdata_out), .data_oe_in(ext_data_oe_out), .rdata_out(ext_rdata_in),
    .wr_addr_out(m_waddr), .wr_data_out(m_wdata));
  // ----------------------------------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // whole run is well under 1000 clocks; 50000 means a hang
  initial
  begin
    #200000;
    n_fail++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wreg
  // read data stands only in the cycle after the strobe, sampled there
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, {8'h00, e}, {8'h00, reg_rdata_out});
  endtask : rchk
  // one instruction, watched clock by clock until its end pulse
  task automatic run_instr(input logic mv, input logic ptr, input logic wr, input logic [2:0] cyc,
                           input logic [15:0] ea, input int elen, input int estb);
    int first, len, fetches, rdc, wrc, bad;
    logic [3:0]  prev;
    logic [15:0] aseen;
    first = -1; len = -1; fetches = 0; rdc = 0; wrc = 0; bad = 0; aseen = 16'h0000;
    @(posedge ref_clk_in);
    instr_req_in <= 1'b1;
    ext_move_in <= mv;
    ext_use_ptr_in <= ptr;
    ext_write_in <= wr;
    op_cycles_in <= cyc;
    op_bytes_in <= cyc;
    port2_in <= ea[15:8];
    ind_ptr_in <= ea[7:0];
    ext_wdata_in <= ea[7:0] ^ 8'h3C;
    @(posedge ref_clk_in);
    instr_req_in <= 1'b0;
    prev = phase_out;
    for (int i = 0; i < 200 && len < 0; i++)
    begin
      #1;
      if (i > 0 && phase_out !== {prev[2:0], prev[3]}) bad++;
      prev = phase_out;
      if (fetch_out === 1'b1)
      begin
        fetches++;
        if (first < 0) first = i;
        if (phase_out !== 4'b0001) bad++;
      end
      if (rd_n_out === 1'b0) rdc++;
      if (wr_n_out === 1'b0)
      begin
        wrc++;
        if (ext_data_oe_out !== 1'b1) bad++;
      end
      if (rd_n_out === 1'b0 || wr_n_out === 1'b0) aseen = ext_addr_out;
      if (busy_out !== ((done_out === 1'b1) ? 1'b0 : 1'b1)) bad++;
      if (done_out === 1'b1) len = i - first;
      if (len < 0) @(posedge ref_clk_in);
    end
    chk("phase order", 16'h0000, 16'(bad));
    chk("length", 16'(elen), 16'(len));
    chk("fetches", mv ? 16'h0001 : 16'(cyc), 16'(fetches));
    chk("read strobe", (mv && !wr) ? 16'(estb) : 16'h0000, 16'(rdc));
    chk("write strobe", (mv && wr) ? 16'(estb) : 16'h0000, 16'(wrc));
    if (mv)
      chk("address", ea, aseen);
    if (mv && !wr)
      chk("read byte", {8'h00, ea[7:0] ^ ea[15:8] ^ 8'hA5}, {8'h00, rdata_out});
    if (mv && wr)
      chk("written", {ea[7:0], ea[7:0] ^ 8'h3C}, {m_waddr[7:0], m_wdata});
  endtask : run_instr
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rchk("clk ctrl", CLK_CTRL_ADDR, 8'h01);
    rchk("ptr sel", PTR_SEL_ADDR, 8'h00);
    rchk("ptr lo", PTR_LO_ADDR, 8'h00);
    rchk("unmapped", 8'h77, 8'h00);
  endtask : t_reset_values
  // other instructions keep 4 clocks per cycle even at the longest stretch
  task automatic t_normal;
    wreg(CLK_CTRL_ADDR, 8'h07);
    for (int n = 1; n <= 5; n++)
      run_instr(1'b0, 1'b0, 1'b0, 3'(n), 16'h0000, 4 * n, 0);
  endtask : t_normal
  task automatic t_ptr_select;
    wreg(PTR_SEL_ADDR, 8'hFF);
    rchk("sel upper bits", PTR_SEL_ADDR, 8'h01);
    wreg(PTR_LO_ADDR, 8'h34);
    wreg(PTR_HI_ADDR, 8'h12);
    wreg(PTR_SEL_ADDR, 8'h00);
    wreg(PTR_LO_ADDR, 8'hCD);
    wreg(PTR_HI_ADDR, 8'hAB);
    rchk("ptr a lo", PTR_LO_ADDR, 8'hCD);
    wreg(PTR_SEL_ADDR, 8'h01);
    rchk("ptr b hi", PTR_HI_ADDR, 8'h12);
    @(posedge ref_clk_in);
    ptr_inc_in <= 1'b1;
    @(posedge ref_clk_in);
    ptr_inc_in <= 1'b0;
    rchk("ptr b inc", PTR_LO_ADDR, 8'h35);
    wreg(CLK_CTRL_ADDR, 8'h01);
    run_instr(1'b1, 1'b1, 1'b0, 3'h1, 16'h1235, 12, 4);
    wreg(PTR_SEL_ADDR, 8'h02);
    rchk("sel after inc", PTR_SEL_ADDR, 8'h00);
  endtask : t_ptr_select
  // every stretch value, a pointer read and an indirect write back to back
  task automatic t_moves;
    for (int s = 0; s < 8; s++)
    begin
      wreg(CLK_CTRL_ADDR, 8'(s));
      rchk("stretch", CLK_CTRL_ADDR, 8'(s));
      run_instr(1'b1, 1'b1, 1'b0, 3'h1, 16'hABCD, 4 * (s + 2), s == 0 ? 2 : 4 * s);
      run_instr(1'b1, 1'b0, 1'b1, 3'h1, {8'(s) ^ 8'hC0, 8'h40 + 8'(s)}, 4 * (s + 2),
                s == 0 ? 2 : 4 * s);
      rchk("last read", RDATA_ADDR, 8'hCD ^ 8'hAB ^ 8'hA5);
      rchk("status", STATUS_ADDR, {5'h00, 3'(s)});
    end
  endtask : t_moves
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    reset_n_in = 1'b0;
    {reg_wr_in, reg_rd_in, instr_req_in, ext_move_in, ext_use_ptr_in, ext_write_in, ptr_inc_in} = 7'h00;
    {reg_addr_in, reg_wdata_in, ind_ptr_in, port2_in, ext_wdata_in} = 40'h0;
    op_bytes_in = 3'h1;
    op_cycles_in = 3'h1;
    repeat (12) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    t_reset_values();
    t_normal();
    t_ptr_select();
    t_moves();
    finish_test();
  end
endmodule : test_ext_data_access_stretch

// *** hdl/ext_data_access_stretch.sv ***
// Purpose : machine cycle sequencer and external data move timing
// Assumes : inputs synchronous to ref_clk_in, strobes active low
// Notes   : instructions always begin on a C1 clock
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ext_data_access_stretch
  import ext_access_pkg::*;
(
  input  wire logic        ref_clk_in,      // 250 MHz clock
  input  wire logic        reset_n_in,      // async reset, active low
  input  wire logic [7:0]  reg_addr_in,     // register address
  input  wire logic [7:0]  reg_wdata_in,    // register write data
  input  wire logic        reg_wr_in,       // register write strobe
  input  wire logic        reg_rd_in,       // register read strobe
  output logic      [7:0]  reg_rdata_out,   // read data, next cycle
  input  wire logic        instr_req_in,    // instruction request pulse
  input  wire logic [2:0]  op_bytes_in,     // instruction bytes
  input  wire logic [2:0]  op_cycles_in,    // machine cycles, normal ops
  input  wire logic        ext_move_in,     // request is an external move
  input  wire logic        ext_use_ptr_in,  // 1 pointer, 0 indirect
  input  wire logic        ext_write_in,    // 1 write, 0 read
  input  wire logic [7:0]  ind_ptr_in,      // indirect pointer register
  input  wire logic [7:0]  port2_in,        // port 2 latch
  input  wire logic [7:0]  ext_wdata_in,    // byte to write
  input  wire logic        ptr_inc_in,      // increment selected pointer
  input  wire logic [7:0]  ext_rdata_in,    // external data bus in
  output logic      [3:0]  phase_out,       // one-hot C1..C4
  output logic             busy_out,        // instruction in progress
  output logic             fetch_out,       // opcode fetch pulse
  output logic             done_out,        // instruction end pulse
  output logic      [15:0] ext_addr_out,    // external address
  output logic             rd_n_out,        // read strobe, low active
  output logic             wr_n_out,        // write strobe, low active
  output logic      [7:0]  ext_wdata_out,   // external data bus out
  output logic             ext_data_oe_out, // drive data bus
  output logic      [7:0]  rdata_out        // captured read byte
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // strobe width in clocks for a stretch value
  function automatic logic [4:0] strobe_w(input logic [2:0] s);
    strobe_w = (s == 3'h0) ? STROBE_MIN : {s, 2'b00};
  endfunction : strobe_w
  // first access clock whose registered strobe is active
  function automatic logic [5:0] strobe_lo(input logic [2:0] s);
    strobe_lo = (s == 3'h0) ? 6'h00 : 6'h01;
  endfunction : strobe_lo
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  seq_state_t  st_r;
  logic [3:0]  ph_r;
  logic        pend_r;
  logic [2:0]  cyc_r;
  logic [2:0]  byt_r;
  logic [2:0]  mc_r;
  logic        ext_r;
  logic        ptr_r;
  logic        wr_r;
  logic [7:0]  ind_r;
  logic [7:0]  p2_r;
  logic [7:0]  wd_r;
  logic [2:0]  str_r;
  logic [5:0]  acc_r;
  logic [2:0]  stretch_r;
  logic        sel_r;
  logic [15:0] ptr_a_r;
  logic [15:0] ptr_b_r;
  logic        fin;
  logic        cont;
  logic        strobe_nxt;
  logic [15:0] ptr_cur;
  logic [5:0]  acc_last;
  assign ptr_cur  = sel_r ? ptr_b_r : ptr_a_r;
  assign acc_last = {1'b0, str_r, 2'b11};      // (stretch+1)*4 - 1
  // ----------------------------------------------------------------
  // machine cycle phase
  // ----------------------------------------------------------------
  // free running rotation keeps C1..C4 order fixed
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
      ph_r <= 4'h1;
    else
      ph_r <= {ph_r[2:0], ph_r[3]};
  assign phase_out = ph_r;
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // end of instruction and continuation into another machine cycle
  always_comb
  begin
    fin  = 1'b0;
    cont = 1'b0;
    case (st_r)
      ST_IDLE:   cont = pend_r & ph_r[3];
      ST_FETCH:
      begin
        cont = ph_r[3] & ~ext_r & (cyc_r > 3'h1);
        fin  = ph_r[3] & ~ext_r & (cyc_r <= 3'h1);
      end
      ST_EXEC:
      begin
        cont = ph_r[3] & (mc_r > 3'h1);
        fin  = ph_r[3] & (mc_r <= 3'h1);
      end
      ST_ACCESS: fin = (acc_r == acc_last);
      default:   fin = 1'b0;
    endcase
  end

  // state, request latch and machine cycle counting
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      st_r   <= ST_IDLE;
      pend_r <= 1'b0;
      cyc_r  <= 3'h1;
      mc_r   <= 3'h0;
      ext_r  <= 1'b0;
      ptr_r  <= 1'b0;
      wr_r   <= 1'b0;
      ind_r  <= 8'h00;
      p2_r   <= 8'h00;
      wd_r   <= 8'h00;
      str_r  <= STRETCH_RST;
      acc_r  <= 6'h00;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          // requests while busy are ignored; wait for the C1 boundary
          if (instr_req_in && !pend_r)
          begin
            pend_r <= 1'b1;
            ext_r  <= ext_move_in;
            ptr_r  <= ext_use_ptr_in;
            wr_r   <= ext_write_in;
            ind_r  <= ind_ptr_in;
            p2_r   <= port2_in;
            wd_r   <= ext_wdata_in;
            // stretch never touches normal lengths, clamp 1..5
            if (op_cycles_in == 3'h0)
              cyc_r <= 3'h1;
            else if (op_cycles_in > MAX_CYCLES)
              cyc_r <= MAX_CYCLES;
            else
              cyc_r <= op_cycles_in;
          end
          if (cont)
          begin
            pend_r <= 1'b0;
            st_r   <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (ph_r[3] && ext_r)
          begin
            st_r  <= ST_ACCESS;
            str_r <= stretch_r; // latched so a mid-move write is harmless
            acc_r <= 6'h00;
          end
          else if (cont)
          begin
            st_r <= ST_EXEC;
            mc_r <= cyc_r - 3'h1;
          end
          else if (fin)
            st_r <= ST_IDLE;
        end
        ST_EXEC:
        begin
          if (fin)
            st_r <= ST_IDLE;
          else if (ph_r[3])
            mc_r <= mc_r - 3'h1;
        end
        ST_ACCESS:
        begin
          // holding CPU state: the access counter is all that moves
          if (fin)
            st_r <= ST_IDLE;
          else
            acc_r <= acc_r + 6'h01;
        end
        default: st_r <= ST_IDLE;
      endcase
    end

  // opcode fetch pulses, one per machine cycle of a normal op, counted from cyc_r, not op_bytes_in; one for a move
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      byt_r     <= 3'h0;
      fetch_out <= 1'b0;
    end
    else
    begin
      fetch_out <= cont && (st_r == ST_IDLE || byt_r != 3'h0);
      if (st_r == ST_IDLE && cont)
        byt_r <= ext_r ? 3'h0 : ((op_bytes_in == 3'h0) ? 3'h0 : 3'h0) | (cyc_r - 3'h1);
      else if (cont && byt_r != 3'h0)
        byt_r <= byt_r - 3'h1;
    end

  // busy and done flags
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= fin;
      busy_out <= (pend_r | instr_req_in | (st_r != ST_IDLE)) & ~fin;
    end
  // ----------------------------------------------------------------
  // external access
  // ----------------------------------------------------------------
  assign strobe_nxt = (st_r == ST_ACCESS) && (acc_r >= strobe_lo(str_r))
                      && (acc_r < strobe_lo(str_r) + {1'b0, strobe_w(str_r)});

  // address, strobes and data bus, all registered
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      ext_addr_out    <= 16'h0000;
      rd_n_out        <= 1'b1;
      wr_n_out        <= 1'b1;
      ext_wdata_out   <= 8'h00;
      ext_data_oe_out <= 1'b0;
      rdata_out       <= 8'h00;
    end
    else
    begin
      if (st_r == ST_FETCH && ph_r[3] && ext_r)
      begin
        if (ptr_r)
          ext_addr_out <= ptr_cur;
        else
          ext_addr_out <= {p2_r, ind_r};
        ext_wdata_out <= wd_r;
      end
      ext_data_oe_out <= (st_r == ST_FETCH && ph_r[3] && ext_r && wr_r)
                         | (st_r == ST_ACCESS && wr_r && !fin);
      rd_n_out <= ~(strobe_nxt & ~wr_r);
      wr_n_out <= ~(strobe_nxt & wr_r);
      // sample on the strobe's last clock; far side has data by then
      if (st_r == ST_ACCESS && !wr_r && !rd_n_out && !strobe_nxt)
        rdata_out <= ext_rdata_in;
    end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // software writes, pointer increments and select
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
    begin
      stretch_r <= STRETCH_RST;
      sel_r     <= PTR_SEL_RST[SEL_BIT];
      ptr_a_r   <= PTR_RST;
      ptr_b_r   <= PTR_RST;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == CLK_CTRL_ADDR)
        stretch_r <= reg_wdata_in[STRETCH_MSB:0];
      if (reg_wr_in && reg_addr_in == PTR_SEL_ADDR)
        sel_r <= reg_wdata_in[SEL_BIT];
      if (reg_wr_in && reg_addr_in == PTR_LO_ADDR)
      begin
        if (sel_r) ptr_b_r[7:0] <= reg_wdata_in;
        else       ptr_a_r[7:0] <= reg_wdata_in;
      end
      else if (reg_wr_in && reg_addr_in == PTR_HI_ADDR)
      begin
        if (sel_r) ptr_b_r[15:8] <= reg_wdata_in;
        else       ptr_a_r[15:8] <= reg_wdata_in;
      end
      else if (ptr_inc_in)
      begin
        if (sel_r) ptr_b_r <= ptr_b_r + 16'h0001;
        else       ptr_a_r <= ptr_a_r + 16'h0001;
      end
    end

  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      case (reg_addr_in)
        PTR_LO_ADDR:   reg_rdata_out <= ptr_cur[7:0];
        PTR_HI_ADDR:   reg_rdata_out <= ptr_cur[15:8];
        PTR_SEL_ADDR:  reg_rdata_out <= {7'h00, sel_r};
        CLK_CTRL_ADDR: reg_rdata_out <= {5'h00, stretch_r};
        STATUS_ADDR:   reg_rdata_out <= {4'h0, st_r != ST_IDLE, str_r};
        RDATA_ADDR:    reg_rdata_out <= rdata_out;
        default:       reg_rdata_out <= 8'h00;
      endcase
    else
      reg_rdata_out <= 8'h00;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] slen_r;
  always_ff @(posedge ref_clk_in or negedge rst_n)
    if (!rst_n)
      slen_r <= 6'h00;
    else
      slen_r <= (!rd_n_out || !wr_n_out) ? slen_r + 6'h01 : 6'h00;

  a_phase_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    ph_r[0] |=> ph_r[1] ##1 ph_r[2] ##1 ph_r[3] ##1 ph_r[0]) else $error("phase order broken");
  a_fetch_c1: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    fetch_out |-> ph_r[0]) else $error("fetch off C1");
  a_single_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (st_r == ST_IDLE && cont && !ext_r && cyc_r == 3'h1) |-> ##5 done_out) else $error("one cycle op length");
  a_exec_bound: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    st_r == ST_EXEC |-> mc_r <= 3'h4) else $error("exec too long");
  a_ind_addr: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (st_r == ST_ACCESS && !ptr_r) |-> ext_addr_out == {p2_r, ind_r}) else $error("indirect address");
  a_sel_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $past(reg_rd_in && reg_addr_in == PTR_SEL_ADDR) |-> reg_rdata_out[7:1] == 7'h00) else $error("select high bits");
  a_move_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (st_r == ST_FETCH && ph_r[3] && ext_r && stretch_r == 3'h0) |-> ##5 done_out) else $error("move length");
  a_strobe_w: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    ($rose(rd_n_out) || $rose(wr_n_out)) |-> slen_r == {1'b0, strobe_w(str_r)}) else $error("strobe width");
  a_reset_str: assert property (@(posedge ref_clk_in)
    $rose(rst_n) |-> stretch_r == STRETCH_RST) else $error("stretch reset value");
endmodule : ext_data_access_stretch

// *** include/ext_access_pkg.sv ***
// Purpose : shared constants for the external data access timing block
// Assumes : 8-bit register port, 4 clocks per machine cycle
// Notes   : offsets are register port addresses
package ext_access_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_LO_ADDR   = 8'h82; // selected pointer, low byte
  localparam logic [7:0] PTR_HI_ADDR   = 8'h83; // selected pointer, high byte
  localparam logic [7:0] PTR_SEL_ADDR  = 8'h86; // pointer select
  localparam logic [7:0] CLK_CTRL_ADDR = 8'h8E; // clock control
  localparam logic [7:0] STATUS_ADDR   = 8'h8F; // block status
  localparam logic [7:0] RDATA_ADDR    = 8'h90; // last external read byte
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         SEL_BIT       = 0;
  localparam int         STRETCH_MSB   = 2;
  localparam logic [2:0] STRETCH_RST   = 3'h1;
  localparam logic [7:0] PTR_SEL_RST   = 8'h00;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PER_MC    = 4;     // clocks per machine cycle
  localparam logic [2:0] MAX_CYCLES    = 3'h5;  // longest normal instruction
  localparam logic [4:0] STROBE_MIN    = 5'h02; // strobe clocks at stretch 0
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FETCH  = 4'b0010,
    ST_EXEC   = 4'b0100,
    ST_ACCESS = 4'b1000
  } seq_state_t;
endpackage : ext_access_pkg
